// ==== src/fault_supervisor_pkg.sv ====
// Constants for the lamp inverter fault supervisor.
//------------------------------------------------------------
// Function
//------------------------------------------------------------
// Function
// - A low lamp-current reading on either feedback input enables the small timer charge current.
// - A fault-timer threshold crossing sets the fault latch and shuts the inverter down.
// - While the fault latch is set the regulator is kept at full output level.
// - The fault latch clears only when the lamp-enable bit is zero or on power-on reset.
// - A secondary overvoltage enables the large compensation discharge source.
// - A primary overcurrent while the low side is on turns the high side off two clock edges later, through the synchroniser.
// - A secondary undervoltage held through the whole delay in the dimming on phase shuts down.
// - A secondary overcurrent enables both the discharge source and the large timer charge current.
// - Power-on reset clears the fault latch and all control state.
// - Undervoltage lockout holds both high-side and low-side drivers disabled.
// - A zero lamp-enable bit means shutdown, with only the regulator on at reduced level.
// - The fault latch is held reset for as long as the device is in shutdown.
// - A one on the lamp-enable bit brings the device out of shutdown.
// - The sensor supply switch is on in the run state and off while disabled or fault-latched.
// - Enabling starts the lamp in the next cycle and disabling stops it in the next cycle.
package fault_supervisor_pkg;

	//------------------------------------------------------------
	// Timing
	//------------------------------------------------------------
	localparam int CLK_FREQ_HZ = 125000000;
	// Nominal undervoltage persistence time in microseconds.
	localparam int UV_DELAY_US = 250;
	localparam int UV_DELAY_CYCLES = (CLK_FREQ_HZ / 1000000) * UV_DELAY_US;
	localparam int UV_CNT_W = 16;

	//------------------------------------------------------------
	// Supervisor states
	//------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_SHUTDOWN = 3'h1,
		ST_RUN = 3'h2,
		ST_FAULT = 3'h4
	} sup_state_e;

endpackage

// ==== src/inverter_fault_supervisor.sv ====
// Fault supervision and shutdown control of the lamp inverter.
`timescale 1ns/1ns
`default_nettype none
module inverter_fault_supervisor #(
	parameter int UV_DELAY_CYCLES = fault_supervisor_pkg::UV_DELAY_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic lampEnableBit,
	input wire logic dimmingChop,
	input wire logic lowSideOn,
	input wire logic lampFeedbackALow,
	input wire logic lampFeedbackBLow,
	input wire logic secondaryVoltOver,
	input wire logic secondaryVoltUnder,
	input wire logic secondaryCurrentOver,
	input wire logic primaryCurrentOver,
	input wire logic faultTimerOver,
	input wire logic undervoltageLockout,
	output logic timerChargeSmallEn,
	output logic timerChargeLargeEn,
	output logic compDischargeEn,
	output logic highSideOff,
	output logic highSideDisable,
	output logic lowSideDisable,
	output logic regulatorFullLevel,
	output logic sensorSupplyOn,
	output logic faultLatched,
	output logic inverterRun
);

	//------------------------------------------------------------
	// Input synchronisers
	//------------------------------------------------------------
	localparam int NSYNC = 9;
	logic [NSYNC-1:0] rawIn;
	logic [NSYNC-1:0] sync1_r;
	logic [NSYNC-1:0] sync2_r;
	logic [NSYNC-1:0] sync1_nxt;
	logic [NSYNC-1:0] sync2_nxt;

	assign rawIn = {dimmingChop, lampFeedbackALow, lampFeedbackBLow,
		secondaryVoltOver, secondaryVoltUnder, secondaryCurrentOver,
		primaryCurrentOver, faultTimerOver, undervoltageLockout};

	// Comparators switch at analog pace, so each bit gets two stages.
	// two-stage synchroniser
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_comb begin
				sync1_nxt[gi] = rawIn[gi];
				sync2_nxt[gi] = sync1_r[gi];
			end
			always_ff @(posedge clk) begin
				if (!rst_b) begin
					sync1_r[gi] <= 1'b0;
					sync2_r[gi] <= 1'b0;
				end else begin
					sync1_r[gi] <= sync1_nxt[gi];
					sync2_r[gi] <= sync2_nxt[gi];
				end
			end
		end
	endgenerate

	logic sChop, sFbA, sFbB, sVOver, sVUnder, sIOver, sPOver, sTimer, sUvlo;
	assign {sChop, sFbA, sFbB, sVOver, sVUnder, sIOver, sPOver, sTimer,
		sUvlo} = sync2_r;

	//------------------------------------------------------------
	// Supervisor state and undervoltage timer
	//------------------------------------------------------------
	fault_supervisor_pkg::sup_state_e state_r, state_nxt;
	logic [fault_supervisor_pkg::UV_CNT_W-1:0] uvCnt_r, uvCnt_nxt;
	logic uvExpired;
	localparam logic [fault_supervisor_pkg::UV_CNT_W-1:0] UV_LAST =
		fault_supervisor_pkg::UV_CNT_W'(UV_DELAY_CYCLES - 1);

	assign uvExpired = sVUnder && sChop && (uvCnt_r == UV_LAST);

	// The enable bit is a same-clock register bit, read without sync.
	always_comb begin
		state_nxt = state_r;
		uvCnt_nxt = uvCnt_r;
		if (state_r == fault_supervisor_pkg::ST_RUN && sChop && sVUnder) begin
			if (uvCnt_r != UV_LAST)
				uvCnt_nxt = uvCnt_r + 1'b1;
		end else begin
			uvCnt_nxt = '0;
		end
		case (state_r)
			fault_supervisor_pkg::ST_SHUTDOWN: begin
				if (lampEnableBit)
					state_nxt = fault_supervisor_pkg::ST_RUN;
			end
			fault_supervisor_pkg::ST_RUN: begin
				if (!lampEnableBit)
					state_nxt = fault_supervisor_pkg::ST_SHUTDOWN;
				else if (sTimer)
					state_nxt = fault_supervisor_pkg::ST_FAULT;
				else if (uvExpired)
					state_nxt = fault_supervisor_pkg::ST_FAULT;
			end
			fault_supervisor_pkg::ST_FAULT: begin
				if (!lampEnableBit)
					state_nxt = fault_supervisor_pkg::ST_SHUTDOWN;
			end
			default: state_nxt = fault_supervisor_pkg::ST_SHUTDOWN;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_r <= fault_supervisor_pkg::ST_SHUTDOWN;
			uvCnt_r <= '0;
		end else begin
			state_r <= state_nxt;
			uvCnt_r <= uvCnt_nxt;
		end
	end

	//------------------------------------------------------------
	// Outputs
	//------------------------------------------------------------
	logic running;
	assign running = (state_r == fault_supervisor_pkg::ST_RUN);

	// Outputs follow state directly, so enable acts the next cycle.
	// immediate start and stop
	always_comb begin
		inverterRun = running;
		faultLatched = (state_r == fault_supervisor_pkg::ST_FAULT);
		regulatorFullLevel = running || faultLatched;
		sensorSupplyOn = running;
		timerChargeSmallEn = running && (sFbA || sFbB);
		timerChargeLargeEn = running && sIOver;
		compDischargeEn = running && (sVOver || sIOver);
		highSideOff = !running || (lowSideOn && sPOver);
		highSideDisable = !running || sUvlo;
		lowSideDisable = !running || sUvlo;
	end

endmodule
`default_nettype wire

// ==== dv/comparator_bank_model.sv ====
// Comparator bank and bridge phase model at the far side.
`timescale 1ns/1ns
`default_nettype none
module comparator_bank_model (
	input wire logic clk,
	input wire logic [7:0] trip,
	output logic [7:0] cmpOut,
	output logic lowSideOn
);
	// Trips settle one edge late, as a real comparator lags its input.
	initial begin
		cmpOut = 8'h00;
		lowSideOn = 1'b0;
	end
	always @(posedge clk) begin
		cmpOut <= trip;
		lowSideOn <= ~lowSideOn;
	end
endmodule
`default_nettype wire

// ==== dv/fault_supervisor_chk.sv ====
// Port checker of the fault supervisor.
`timescale 1ns/1ns
`default_nettype none
module fault_supervisor_chk (
	input wire logic clk, rst_b, lampEnableBit, lowSideOn, faultTimerOver,
	input wire logic lampFeedbackALow, lampFeedbackBLow, secondaryVoltOver,
	input wire logic secondaryCurrentOver, primaryCurrentOver,
	input wire logic undervoltageLockout, timerChargeSmallEn, highSideOff,
	input wire logic timerChargeLargeEn, compDischargeEn, highSideDisable,
	input wire logic lowSideDisable, regulatorFullLevel, sensorSupplyOn,
	input wire logic faultLatched, inverterRun
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Trips reach the outputs two edges later, through the synchronisers.
	AST_SMALL:
	assert property (inverterRun |-> timerChargeSmallEn ==
		$past(lampFeedbackALow | lampFeedbackBLow, 2)) else $error("small");
	AST_DISCH:
	assert property (inverterRun |-> {compDischargeEn, timerChargeLargeEn} ==
		{$past(secondaryVoltOver | secondaryCurrentOver, 2),
		$past(secondaryCurrentOver, 2)}) else $error("disch");
	AST_HSOFF:
	assert property (inverterRun && lowSideOn && $past(primaryCurrentOver, 2)
		|-> highSideOff) else $error("hs off");
	AST_UNDERVOLTAGE_LOCKOUT:
	assert property ($past(undervoltageLockout, 2)
		|-> highSideDisable && lowSideDisable) else $error("undervoltage_lockout");
	AST_FAULT:
	assert property (inverterRun && faultTimerOver |-> ##3
		faultLatched && !inverterRun) else $error("fault");
	AST_REG:
	assert property (faultLatched |-> regulatorFullLevel) else $error("reg");
	AST_STOP:
	assert property (!lampEnableBit |=> !faultLatched && !inverterRun
		&& !sensorSupplyOn) else $error("stop");
	AST_START:
	assert property ($rose(lampEnableBit) && !faultLatched |=> inverterRun)
		else $error("start");
endmodule
bind inverter_fault_supervisor fault_supervisor_chk chk_u (.*);
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench of the fault supervisor.
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic en = 1'b0;
	logic chop = 1'b0;
	logic [7:0] trip = 8'h00;
	wire lso;
	wire [7:0] c;
	wire [9:0] o;
	logic [2:0] expQ[$];
	int err_total = 0;
	int checks_done = 0;
	int seed = 15;
	event probe;
	always #4 clk = ~clk;
	comparator_bank_model model_u (.clk(clk), .trip(trip), .cmpOut(c),
		.lowSideOn(lso));
	// Short undervoltage count keeps the run brief.
	inverter_fault_supervisor #(.UV_DELAY_CYCLES(8)) dut_u (.clk(clk),
		.rst_b(rst_b), .lampEnableBit(en), .dimmingChop(chop), .lowSideOn(lso),
		.lampFeedbackALow(c[0]), .lampFeedbackBLow(c[1]),
		.secondaryVoltOver(c[2]), .secondaryVoltUnder(c[3]),
		.secondaryCurrentOver(c[4]), .primaryCurrentOver(c[5]),
		.faultTimerOver(c[6]), .undervoltageLockout(c[7]),
		.timerChargeSmallEn(o[0]), .timerChargeLargeEn(o[1]),
		.compDischargeEn(o[2]), .highSideOff(o[3]), .highSideDisable(o[4]),
		.lowSideDisable(o[5]), .regulatorFullLevel(o[6]),
		.sensorSupplyOn(o[7]), .faultLatched(o[8]), .inverterRun(o[9]));
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic note(input logic [2:0] v);
		expQ.push_back(v);
		-> probe;
	endtask
	task automatic report_and_stop;
		if (err_total == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Compares {latched, run, full level} with the oldest note.
	always @(probe) begin
		checks_done++;
		if ({o[8], o[9], o[6]} !== expQ[0]) begin
			err_total++;
			$display("[FAIL] state exp %b seen %b", expQ[0], {o[8], o[9], o[6]});
		end
		void'(expQ.pop_front());
	end
	initial begin
		step(6);
		rst_b = 1'b1;
		step(2);
		note(3'b000);
		en = 1'b1;
		step(1);
		note(3'b011);
		for (int i = 0; i < 40; i++) begin
			trip = 8'($random(seed)) & 8'hB7;
			step(1);
		end
		trip = 8'h00;
		chop = 1'b1;
		// Two broken undervoltage spells must not add up to a fault.
		repeat (2) begin
			trip = 8'h08;
			step(6);
			trip = 8'h00;
			step(1);
		end
		step(3);
		note(3'b011);
		trip = 8'h08;
		step(14);
		note(3'b101);
		trip = 8'h00;
		step(2);
		note(3'b101);
		en = 1'b0;
		chop = 1'b0;
		step(1);
		note(3'b000);
		en = 1'b1;
		trip = 8'h40;
		step(8);
		note(3'b101);
		trip = 8'h00;
		en = 1'b0;
		step(1);
		note(3'b000);
		step(1);
		report_and_stop;
	end
	initial begin
		#5000;
		err_total++;
		report_and_stop;
	end
endmodule
`default_nettype wire
